// *** seu_pkg.sv ***
// constants and carrier types of the soft error sensitivity lookup
// assumes one clock, synchronous active-high reset, byte-addressed map memory
// Functional notes
// - cache depth 2, 4, 8, 16, 32 or 64, default 8
// - report width follows largest region id
// - on-chip option builds memory master
// - memory address width parameter, default 32
// - start offset added to every address
// - tag zero reports no region unless the cache is full
// - first format critical reports region 1
// - frame, byte, bit taken from message word
// - first format descriptor at 0x14+frame*4
// - position read from group table entry
// - bitmap byte at pos/8 plus bases
// - pos bits 2:0 pick bitmap bit
// - second format descriptor at 0x1C+frame*4
// - second format position is 16 bits
// - descriptor bits 7:0 selector, 31:8 base
// - second format tag shifted, masked, zero non-critical
// - nonzero tag reads 16-bit region mask
package seu_pkg;

	////////////////////////////////////////////////////////////////
	// message word layout
	localparam int EMW_W      = 32;
	localparam int FRAME_LSB  = 16;
	localparam int FRAME_W    = 16;
	localparam int BYTE_LSB   = 3;
	localparam int BYTE_W     = 13;
	localparam int BIT_LSB    = 0;
	localparam int BIT_W      = 3;

	////////////////////////////////////////////////////////////////
	// map image layout
	localparam logic [31:0] FRAME_BASE_FMT1 = 32'h0000_0014;
	localparam logic [31:0] FRAME_BASE_FMT2 = 32'h0000_001c;
	localparam int          SEL_W           = 8;
	localparam int          FBASE_W         = 24;
	localparam int          REGION_MASK_W   = 16;

	////////////////////////////////////////////////////////////////
	// register byte offsets
	localparam logic [4:0] OFS_CTRL    = 5'h00;
	localparam logic [4:0] OFS_GROUP   = 5'h04;
	localparam logic [4:0] OFS_SPAN    = 5'h08;
	localparam logic [4:0] OFS_BITMAP  = 5'h0c;
	localparam logic [4:0] OFS_REGION  = 5'h10;
	localparam logic [4:0] OFS_STATUS  = 5'h14;
	localparam logic [4:0] OFS_LASTREG = 5'h18;

	// control fields and reset values
	localparam int          CTRL_FMT_BIT   = 0;
	localparam int          CTRL_TAGW_LSB  = 4;
	localparam int          CTRL_CLEAR_BIT = 31;
	localparam logic [31:0] CTRL_RESET     = 32'h0000_0010;
	localparam logic [31:0] ORIGIN_RESET   = 32'h0000_0000;

	// read sizes on the map port
	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_HALF = 2'h1;
	localparam logic [1:0] SZ_WORD = 2'h2;

	typedef struct packed {
		logic [FRAME_W-1:0] frame;
		logic [BYTE_W-1:0]  byte_no;
		logic [BIT_W-1:0]   bit_no;
	} err_loc_s;

	typedef struct packed {
		logic        second_fmt;
		logic [3:0]  tag_width;
		logic [31:0] group_origin;
		logic [31:0] group_span;
		logic [31:0] bitmap_origin;
		logic [31:0] region_origin;
	} map_cfg_s;

	typedef enum logic [2:0] {
		S_IDLE, S_FRAME, S_GROUP, S_SENS, S_REGION, S_DONE
	} lookup_state_e;

endpackage

// *** err_cache.sv ***
// non-critical location cache: remembers locations already judged harmless
// assumes insert is only pulsed when the key is not already held
`timescale 1ns/1ps
module err_cache #(
	parameter int DEPTH = 8,
	parameter int KEY_W = 32
) (
	input  wire logic                       clk,
	input  wire logic                       rst,
	input  wire logic                       clear,
	input  wire logic [KEY_W-1:0]           key,
	input  wire logic                       insert,
	output logic                            hit,
	output logic                            full,
	output logic [$clog2(DEPTH+1)-1:0]      count
);
	logic [KEY_W-1:0]           keys_q [DEPTH];
	logic [$clog2(DEPTH+1)-1:0] used_q;
	logic [DEPTH-1:0]           match;

	// one comparator per entry, only filled entries count
	for (genvar i = 0; i < DEPTH; i++)
	begin : g_cmp
		assign match[i] = (i < used_q) && (keys_q[i] == key);
	end

	assign hit   = |match;
	assign full  = (used_q == ($clog2(DEPTH+1))'(DEPTH));
	assign count = used_q;

	// in-order fill, no eviction; an insert beside a clear wins
	always_ff @(posedge clk)
	begin
		if (rst || (clear && !insert))
			used_q <= '0;
		else if (insert && (clear || !full))
		begin
			keys_q[clear ? '0 : used_q[$clog2(DEPTH)-1:0]] <= key;
			used_q <= (clear ? '0 : used_q) + 1'b1;
		end
	end
endmodule

// *** map_reader.sv ***
// single read master towards the map memory, one request at a time
// assumes aligned half-words and little-endian byte lanes in each word
`timescale 1ns/1ps
module map_reader #(
	parameter int          ADDR_W = 32,
	parameter logic [31:0] START  = 32'h0000_0000
) (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              start,
	input  wire logic [31:0]       addr,
	input  wire logic [1:0]        size,
	output logic                   done,
	output logic [31:0]            data,
	output logic                   mem_read,
	output logic [ADDR_W-1:0]      mem_address,
	input  wire logic              mem_waitrequest,
	input  wire logic [31:0]       mem_readdata
);
	logic        busy_q;
	logic [31:0] addr_q;
	logic [1:0]  size_q;
	logic [31:0] lane;
	logic [31:0] full_addr;

	// word-aligned fetch, offset applied on every request
	assign full_addr   = START + {addr_q[31:2], 2'b00};
	assign mem_address = full_addr[ADDR_W-1:0];
	assign mem_read    = busy_q;
	assign lane        = (size_q == seu_pkg::SZ_WORD) ? mem_readdata :
	                     (size_q == seu_pkg::SZ_HALF) ?
	                     {16'h0000, mem_readdata[addr_q[1]*16 +: 16]} :
	                     {24'h000000, mem_readdata[addr_q[1:0]*8 +: 8]};

	// request stays up until the slave drops waitrequest
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			busy_q <= 1'b0;
			done   <= 1'b0;
			data   <= '0;
			addr_q <= '0;
			size_q <= seu_pkg::SZ_WORD;
		end
		else
		begin
			done <= busy_q && !mem_waitrequest;
			if (busy_q && !mem_waitrequest)
			begin
				busy_q <= 1'b0;
				data   <= lane;
			end
			else if (start && !busy_q)
			begin
				busy_q <= 1'b1;
				addr_q <= addr;
				size_q <= size;
			end
		end
	end
endmodule

// *** seu_lookup.sv ***
// sensitivity lookup engine: classifies a located configuration upset
// assumes the map image is preloaded and the unloader drives the message inputs
//
// Register access over Avalon-MM and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module seu_lookup #(
	parameter int          CACHE_DEPTH = 8,
	parameter int          REGION_MAX  = 1,
	parameter bit          ON_CHIP     = 1'b1,
	parameter int          ADDR_W      = 32,
	parameter logic [31:0] START       = 32'h0000_0000
) (
	input  wire logic                        clk,
	input  wire logic                        rst,
	input  wire logic [seu_pkg::EMW_W-1:0]   error_message_word,
	input  wire logic                        error_message_present,
	input  wire logic                        error_message_fault,
	input  wire logic [4:0]                  avs_address,
	input  wire logic                        avs_read,
	input  wire logic                        avs_write,
	input  wire logic [31:0]                 avs_writedata,
	input  wire logic [3:0]                  avs_byteenable,
	output logic [31:0]                      avs_readdata,
	output logic                             avs_waitrequest,
	output logic                             mem_read,
	output logic [ADDR_W-1:0]                mem_address,
	input  wire logic                        mem_waitrequest,
	input  wire logic [31:0]                 mem_readdata,
	output logic                             lookup_busy,
	output logic                             critical_error,
	output logic                             noncritical_error,
	output logic [REGION_MAX-1:0]            regions_report,
	output logic                             offchip_valid,
	output logic [seu_pkg::EMW_W-1:0]        offchip_location
);

	////////////////////////////////////////////////////////////////
	// build-time checks on the parameter ranges
	localparam int KEY_W = $bits(seu_pkg::err_loc_s);

	initial
	begin
		if (!(CACHE_DEPTH inside {2, 4, 8, 16, 32, 64}))
			$error("cache depth must be 2, 4, 8, 16, 32 or 64");
		if (REGION_MAX < 1 || REGION_MAX > 255)
			$error("largest region id must be 1 to 255");
		if (ADDR_W < 1 || ADDR_W > 32)
			$error("memory address width must be 1 to 32");
	end

	////////////////////////////////////////////////////////////////
	// register bus slave
	seu_pkg::map_cfg_s cfg;
	logic [31:0] ctrl_q;
	logic [31:0] group_q;
	logic [31:0] span_q;
	logic [31:0] bitmap_q;
	logic [31:0] region_q;
	logic [31:0] last_regions_q;
	logic        last_critical_q;
	logic        ack_q;
	logic [31:0] be_mask;
	logic        wr_go;
	logic        rd_go;
	logic        sel_ctrl;
	logic        sel_group;
	logic        sel_span;
	logic        sel_bitmap;
	logic        sel_region;
	logic        cache_clear;
	logic [31:0] status_word;
	logic [31:0] rd_mux;
	logic [$clog2(CACHE_DEPTH+1)-1:0] cache_count;

	// one wait state per access, so every access answers at the second edge
	assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
	assign wr_go      = avs_write && ack_q;
	assign rd_go      = avs_read && !ack_q;
	assign be_mask    = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
	                     {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
	assign sel_ctrl   = wr_go && (avs_address == seu_pkg::OFS_CTRL);
	assign sel_group  = wr_go && (avs_address == seu_pkg::OFS_GROUP);
	assign sel_span   = wr_go && (avs_address == seu_pkg::OFS_SPAN);
	assign sel_bitmap = wr_go && (avs_address == seu_pkg::OFS_BITMAP);
	assign sel_region = wr_go && (avs_address == seu_pkg::OFS_REGION);
	// writing the clear bit empties the cache, the bit itself never stores
	assign cache_clear = sel_ctrl && avs_byteenable[3] &&
	                     avs_writedata[seu_pkg::CTRL_CLEAR_BIT];

	assign cfg.second_fmt    = ctrl_q[seu_pkg::CTRL_FMT_BIT];
	assign cfg.tag_width     = ctrl_q[seu_pkg::CTRL_TAGW_LSB +: 4];
	assign cfg.group_origin  = group_q;
	assign cfg.group_span    = span_q;
	assign cfg.bitmap_origin = bitmap_q;
	assign cfg.region_origin = region_q;

	assign status_word = {15'h0000, last_critical_q,
	                      (8)'(cache_count), 7'h00, lookup_busy};

	// unmapped offsets read as zero
	assign rd_mux = (avs_address == seu_pkg::OFS_CTRL)    ? ctrl_q :
	                (avs_address == seu_pkg::OFS_GROUP)   ? group_q :
	                (avs_address == seu_pkg::OFS_SPAN)    ? span_q :
	                (avs_address == seu_pkg::OFS_BITMAP)  ? bitmap_q :
	                (avs_address == seu_pkg::OFS_REGION)  ? region_q :
	                (avs_address == seu_pkg::OFS_STATUS)  ? status_word :
	                (avs_address == seu_pkg::OFS_LASTREG) ? last_regions_q :
	                32'h0000_0000;

	function automatic logic [31:0] merge(input logic [31:0] old,
	                                      input logic [31:0] nw,
	                                      input logic [31:0] m);
		merge = (old & ~m) | (nw & m);
	endfunction

	// registers written under byte enables
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ack_q        <= 1'b0;
			avs_readdata <= '0;
			ctrl_q       <= seu_pkg::CTRL_RESET;
			group_q      <= seu_pkg::ORIGIN_RESET;
			span_q       <= seu_pkg::ORIGIN_RESET;
			bitmap_q     <= seu_pkg::ORIGIN_RESET;
			region_q     <= seu_pkg::ORIGIN_RESET;
		end
		else
		begin
			ack_q <= (avs_read || avs_write) && !ack_q;
			if (rd_go)
				avs_readdata <= rd_mux;
			if (sel_ctrl)
				ctrl_q <= merge(ctrl_q, avs_writedata, be_mask) & 32'h0000_00f1;
			if (sel_group)
				group_q <= merge(group_q, avs_writedata, be_mask);
			if (sel_span)
				span_q <= merge(span_q, avs_writedata, be_mask);
			if (sel_bitmap)
				bitmap_q <= merge(bitmap_q, avs_writedata, be_mask);
			if (sel_region)
				region_q <= merge(region_q, avs_writedata, be_mask);
		end
	end

	////////////////////////////////////////////////////////////////
	// incoming location and cache
	seu_pkg::err_loc_s in_loc;
	seu_pkg::err_loc_s loc_q;
	logic              cache_hit;
	logic              cache_full;
	logic              cache_insert;
	logic              accept;

	// location fields of the message word
	assign in_loc.frame   = error_message_word[seu_pkg::FRAME_LSB +: seu_pkg::FRAME_W];
	assign in_loc.byte_no = error_message_word[seu_pkg::BYTE_LSB +: seu_pkg::BYTE_W];
	assign in_loc.bit_no  = error_message_word[seu_pkg::BIT_LSB +: seu_pkg::BIT_W];

	err_cache #(
		.DEPTH (CACHE_DEPTH),
		.KEY_W (KEY_W)
	) u_cache (
		.clk    (clk),
		.rst    (rst),
		.clear  (cache_clear),
		.key    (lookup_busy ? loc_q : in_loc),
		.insert (cache_insert),
		.hit    (cache_hit),
		.full   (cache_full),
		.count  (cache_count)
	);

	////////////////////////////////////////////////////////////////
	// map memory master, present only with on-chip processing
	logic        rd_start;
	logic [31:0] rd_addr;
	logic [1:0]  rd_size;
	logic        rd_done;
	logic [31:0] rd_data;

	if (ON_CHIP)
	begin : g_mem
		map_reader #(
			.ADDR_W (ADDR_W),
			.START  (START)
		) u_reader (
			.clk             (clk),
			.rst             (rst),
			.start           (rd_start),
			.addr            (rd_addr),
			.size            (rd_size),
			.done            (rd_done),
			.data            (rd_data),
			.mem_read        (mem_read),
			.mem_address     (mem_address),
			.mem_waitrequest (mem_waitrequest),
			.mem_readdata    (mem_readdata)
		);
	end
	else
	begin : g_nomem
		assign mem_read    = 1'b0;
		assign mem_address = '0;
		assign rd_done     = 1'b0;
		assign rd_data     = '0;
	end

	////////////////////////////////////////////////////////////////
	// lookup sequencer
	seu_pkg::lookup_state_e state_q;
	seu_pkg::lookup_state_e state_d;
	logic [seu_pkg::SEL_W-1:0]   sel_q;
	logic [seu_pkg::FBASE_W-1:0] fbase_q;
	logic [15:0]                 pos_q;
	logic [7:0]                  tag_q;
	logic                        crit_q;
	logic [15:0]                 mask_q;
	logic                        issued_q;
	logic [31:0]                 frame_addr;
	logic [31:0]                 group_addr;
	logic [31:0]                 sens_addr;
	logic [31:0]                 region_addr;
	logic [31:0]                 tag_bits;
	logic [7:0]                  tag_mask;
	logic [7:0]                  tag_val;
	logic [2:0]                  tag_shift;
	logic                        bitmap_bit;

	assign accept = error_message_present && !lookup_busy;

	// address arithmetic for each map read
	assign frame_addr  = (cfg.second_fmt ? seu_pkg::FRAME_BASE_FMT2
	                                     : seu_pkg::FRAME_BASE_FMT1)
	                     + {14'h0000, loc_q.frame, 2'b00};
	assign group_addr  = cfg.group_origin + 32'(sel_q) * cfg.group_span
	                     + {15'h0000, loc_q.byte_no, loc_q.bit_no, 1'b0};
	assign tag_bits    = cfg.second_fmt ? 32'(pos_q) * 32'(cfg.tag_width)
	                                    : 32'(pos_q);
	assign sens_addr   = {3'b000, tag_bits[31:3]} + cfg.bitmap_origin
	                     + {8'h00, fbase_q};
	assign region_addr = cfg.region_origin + {23'h0, tag_val - 8'h01, 1'b0};
	assign tag_shift   = tag_bits[2:0];
	assign tag_mask    = 8'((9'h001 << cfg.tag_width) - 9'h001);
	assign tag_val     = (rd_data[7:0] >> tag_shift) & tag_mask;
	assign bitmap_bit  = rd_data[pos_q[2:0]];

	// a read is issued on the first cycle of each fetch state
	assign rd_start = !issued_q && (state_q != seu_pkg::S_IDLE)
	                  && (state_q != seu_pkg::S_DONE);
	assign rd_addr  = (state_q == seu_pkg::S_FRAME)  ? frame_addr :
	                  (state_q == seu_pkg::S_GROUP)  ? group_addr :
	                  (state_q == seu_pkg::S_SENS)   ? sens_addr : region_addr;
	assign rd_size  = (state_q == seu_pkg::S_FRAME) ? seu_pkg::SZ_WORD :
	                  (state_q == seu_pkg::S_SENS)  ? seu_pkg::SZ_BYTE
	                                                : seu_pkg::SZ_HALF;
	// noncritical results fill the cache while it has room
	assign cache_insert = (state_q == seu_pkg::S_DONE) && !crit_q && !cache_full;
	assign lookup_busy  = (state_q != seu_pkg::S_IDLE);

	// next state
	always_comb
	begin
		state_d = state_q;
		unique case (state_q)
			seu_pkg::S_IDLE:
				if (accept && !error_message_fault && !cache_hit && ON_CHIP)
					state_d = seu_pkg::S_FRAME;
			seu_pkg::S_FRAME:
				if (rd_done)
					state_d = seu_pkg::S_GROUP;
			seu_pkg::S_GROUP:
				if (rd_done)
					state_d = seu_pkg::S_SENS;
			seu_pkg::S_SENS:
				if (rd_done)
					state_d = (cfg.second_fmt && tag_val != 8'h00) ?
					          seu_pkg::S_REGION : seu_pkg::S_DONE;
			seu_pkg::S_REGION:
				if (rd_done)
					state_d = seu_pkg::S_DONE;
			seu_pkg::S_DONE:
				state_d = seu_pkg::S_IDLE;
		endcase
	end

	// sequencer registers and captured map values
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state_q  <= seu_pkg::S_IDLE;
			issued_q <= 1'b0;
			loc_q    <= '0;
			sel_q    <= '0;
			fbase_q  <= '0;
			pos_q    <= '0;
			tag_q    <= '0;
			crit_q   <= 1'b0;
			mask_q   <= '0;
		end
		else
		begin
			state_q  <= state_d;
			issued_q <= (state_d == state_q) && (issued_q || rd_start);
			if (state_q == seu_pkg::S_IDLE && accept)
				loc_q <= in_loc;
			if (state_q == seu_pkg::S_FRAME && rd_done)
			begin
				sel_q   <= rd_data[7:0];
				fbase_q <= rd_data[31:8];
			end
			if (state_q == seu_pkg::S_GROUP && rd_done)
				pos_q <= rd_data[15:0];
			if (state_q == seu_pkg::S_SENS && rd_done)
			begin
				tag_q  <= tag_val;
				// first format: set bit means region 1
				crit_q <= cfg.second_fmt ? (tag_val != 8'h00) : bitmap_bit;
				mask_q <= cfg.second_fmt ? 16'h0000 : 16'h0001;
			end
			if (state_q == seu_pkg::S_REGION && rd_done)
				mask_q <= rd_data[15:0];
		end
	end

	////////////////////////////////////////////////////////////////
	// result outputs
	logic [15:0]           fin_mask;
	logic                  fin_crit;
	logic                  fin_event;
	logic                  quick_crit;
	logic [REGION_MAX-1:0] report_d;

	// a fault or an unplaceable harmless result is taken as critical everywhere
	assign quick_crit = accept && error_message_fault;
	assign fin_event  = (state_q == seu_pkg::S_DONE) || quick_crit;
	assign fin_crit   = quick_crit || crit_q || cache_full;
	assign fin_mask   = (quick_crit || (!crit_q && cache_full)) ? 16'hffff : mask_q;

	// region i+1 maps to mask bit i; ids past the mask width never report
	for (genvar i = 0; i < REGION_MAX; i++)
	begin : g_rep
		if (i < seu_pkg::REGION_MASK_W)
		begin : g_in
			assign report_d[i] = fin_mask[i] && fin_crit;
		end
		else
		begin : g_out
			assign report_d[i] = 1'b0;
		end
	end

	// result pulses, report vector held until the next result
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			critical_error    <= 1'b0;
			noncritical_error <= 1'b0;
			regions_report    <= '0;
			last_regions_q    <= '0;
			last_critical_q   <= 1'b0;
			offchip_valid     <= 1'b0;
			offchip_location  <= '0;
		end
		else
		begin
			critical_error    <= fin_event && fin_crit;
			noncritical_error <= fin_event && !fin_crit;
			// without on-chip processing the location is handed out as is
			offchip_valid     <= !ON_CHIP && accept && !error_message_fault && !cache_hit;
			if (accept)
				offchip_location <= error_message_word;
			if (fin_event)
			begin
				regions_report  <= report_d;
				last_regions_q  <= 32'(fin_mask & {16{fin_crit}});
				last_critical_q <= fin_crit;
			end
		end
	end
endmodule

// *** seu_lookup_properties.sv ***
// checker: result pulses, map reads, busy window
// assumes the on-chip option
`timescale 1ns/1ps
module seu_lookup_properties #(
	parameter int REGION_MAX = 1,
	parameter int ADDR_W     = 32
) (
	input wire logic                  clk,
	input wire logic                  rst,
	input wire logic                  error_message_present,
	input wire logic                  error_message_fault,
	input wire logic                  mem_read,
	input wire logic [ADDR_W-1:0]     mem_address,
	input wire logic                  mem_waitrequest,
	input wire logic                  lookup_busy,
	input wire logic                  critical_error,
	input wire logic                  noncritical_error,
	input wire logic [REGION_MAX-1:0] regions_report,
	input wire logic                  offchip_valid
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	////////////////////////////////////////////////////////////////
	// map port
	property p_mem_hold; mem_read && mem_waitrequest |=> mem_read && $stable(mem_address); endproperty
	a_mem_hold: assert property (p_mem_hold) else $error("stalled read moved");
	property p_mem_busy; mem_read |-> lookup_busy; endproperty
	a_mem_busy: assert property (p_mem_busy) else $error("read outside lookup");
	property p_no_off; !offchip_valid; endproperty
	a_no_off: assert property (p_no_off) else $error("offchip pulse");

	////////////////////////////////////////////////////////////////
	// result pulses
	property p_excl; !(critical_error && noncritical_error); endproperty
	a_excl: assert property (p_excl) else $error("both result pulses");
	property p_pulse; critical_error |=> !critical_error || $past(error_message_fault); endproperty
	a_pulse: assert property (p_pulse) else $error("long pulse");
	property p_fault; error_message_present && error_message_fault && !lookup_busy |=> critical_error; endproperty
	a_fault: assert property (p_fault) else $error("fault not critical");
	property p_nc_zero; noncritical_error |-> regions_report == '0; endproperty
	a_nc_zero: assert property (p_nc_zero) else $error("noncritical region");
	property p_crit_reg; critical_error |-> regions_report != '0; endproperty
	a_crit_reg: assert property (p_crit_reg) else $error("critical without region");
	property p_end; $fell(lookup_busy) |-> critical_error || noncritical_error; endproperty
	a_end: assert property (p_end) else $error("lookup end, no result");

	c_crit: cover property (critical_error);
	c_nc: cover property (noncritical_error);
	c_stall: cover property (mem_read && mem_waitrequest);
endmodule

bind seu_lookup seu_lookup_properties #(.REGION_MAX(REGION_MAX), .ADDR_W(ADDR_W)) u_props (
	.clk, .rst, .error_message_present, .error_message_fault, .mem_read, .mem_address,
	.mem_waitrequest, .lookup_busy, .critical_error, .noncritical_error, .regions_report, .offchip_valid);

// *** map_mem.sv ***
// map memory model: byte array behind a read-only avalon slave
// assumes 4 KiB of map, little-endian lanes
`timescale 1ns/1ps
module map_mem (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        slow,
	input  wire logic        mem_read,
	input  wire logic [31:0] mem_address,
	output logic             mem_waitrequest,
	output logic [31:0]      mem_readdata
);
	logic [7:0]  m [0:4095];
	logic [11:0] a;
	logic [1:0]  w_q;
	logic [31:0] last_q;

	// slow mode stalls each read three cycles
	assign a = {mem_address[11:2], 2'h0};
	assign mem_waitrequest = mem_read && slow && w_q != 2'h3;
	always_ff @(posedge clk)
		w_q <= (rst || !mem_waitrequest) ? 2'h0 : w_q + 2'h1;

	// idle bus shows the inverse of the last word
	assign mem_readdata = (mem_read && !mem_waitrequest) ? {m[a+3], m[a+2], m[a+1], m[a]} : ~last_q;
	always_ff @(posedge clk)
		if (rst)
			last_q <= '0;
		else if (mem_read && !mem_waitrequest)
			last_q <= mem_readdata;
endmodule

// *** seu_lookup_tb.sv ***
// bench: map image in a memory model, avalon-mm registers
// assumes the bound checker; cache depth 2, four regions
`timescale 1ns/1ps
module seu_lookup_tb;
	localparam logic [31:0] ST = 32'h0000_0800;
	logic        clk, rst, slow, avs_read, avs_write, avs_waitrequest, mem_read, mem_waitrequest, offchip_valid;
	logic        error_message_present, error_message_fault, lookup_busy, critical_error, noncritical_error;
	logic [31:0] error_message_word, avs_writedata, avs_readdata, q, mem_address, mem_readdata, offchip_location;
	logic [4:0]  avs_address;
	logic [3:0]  regions_report, avs_byteenable;
	logic [31:0] seen[$];
	int          err_total, n_checks;

	seu_lookup #(.CACHE_DEPTH(2), .REGION_MAX(4), .START(ST)) u_seu_lookup (.clk, .rst, .error_message_word,
		.error_message_present, .error_message_fault, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .mem_read, .mem_address, .mem_waitrequest,
		.mem_readdata, .lookup_busy, .critical_error, .noncritical_error, .regions_report, .offchip_valid,
		.offchip_location);
	map_mem u_map_mem (.clk, .rst, .slow, .mem_read, .mem_address, .mem_waitrequest, .mem_readdata);

	// clock; log of granted map reads
	initial clk = 1'b0;
	always #2 clk = ~clk;
	always @(posedge clk)
		if (mem_read && !mem_waitrequest)
			seen.push_back(mem_address);

	////////////////////////////////////////////////////////////////
	task automatic test_done();
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e)
		begin
			err_total++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		{avs_write, avs_read, avs_address, avs_writedata} <= {w, !w, a, d};
		@(posedge clk);
		while (avs_waitrequest !== 1'b0 && n < 50)
		begin
			n++;
			@(posedge clk);
		end
		q = avs_readdata;
		{avs_write, avs_read} <= 2'h0;
		if (n >= 50)
		begin
			err_total++;
			test_done();
		end
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(q, e);
	endtask
	task automatic pb(input logic [31:0] a, input logic [7:0] v);
		u_map_mem.m[12'(ST + a)] = v;
	endtask
	task automatic ph(input logic [31:0] a, input logic [15:0] v);
		pb(a, v[7:0]);
		pb(a + 1, v[15:8]);
	endtask
	task automatic inj(input logic [31:0] w, input logic f);
		int n;
		n = 0;
		@(negedge clk);
		while (lookup_busy !== 1'b0 && n < 500)
		begin
			n++;
			@(negedge clk);
		end
		chk(n >= 500, 1'b0);
		@(posedge clk);
		{error_message_word, error_message_present, error_message_fault} <= {w, 1'b1, f};
		@(posedge clk);
		{error_message_present, error_message_fault} <= 2'h0;
	endtask
	task automatic res(input logic [1:0] e, input logic [3:0] r);
		int n;
		n = 0;
		@(negedge clk);
		while (!(critical_error || noncritical_error) && n < 300)
		begin
			n++;
			@(negedge clk);
		end
		chk({critical_error, noncritical_error}, e);
		if (e != 2'h0)
			chk(regions_report, r);
	endtask
	task automatic ex(input logic [31:0] a);
		chk(seen.size() > 0 ? seen.pop_front() : 'x, ST + {a[31:2], 2'h0});
	endtask

	////////////////////////////////////////////////////////////////
	initial
	begin
		{err_total, n_checks} = 0;
		{rst, slow, error_message_word, error_message_present, error_message_fault} = {2'h2, 34'h0};
		{avs_address, avs_read, avs_write, avs_writedata, avs_byteenable} = {39'h0, 4'hf};
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		// frame 2: base 0x40, group 1; frame 3: base 0x80, group 0
		pb(32'h1c, 8'h01);
		pb(32'h1d, 8'h40);
		pb(32'h29, 8'h80);
		ph(32'h152, 16'h0018);
		ph(32'h154, 16'h001f);
		ph(32'h156, 16'h001d);
		ph(32'h158, 16'h001e);
		ph(32'h100, 16'h0005);
		ph(32'h102, 16'h0006);
		pb(32'h243, 8'h20);
		pb(32'h281, 8'h08);
		ph(32'h302, 16'h0006);
		{u_map_mem.m[12'h81e], u_map_mem.m[12'h81f], u_map_mem.m[12'h82a], u_map_mem.m[12'h82b]} = 32'h0;
		u_map_mem.m[12'h828] = 8'h00;
		rd(5'h00, seu_pkg::CTRL_RESET);
		bus(1'b1, 5'h1c, 32'hffff_ffff);
		rd(5'h1c, 32'h0);
		bus(1'b1, 5'h04, 32'h100);
		bus(1'b1, 5'h08, 32'h40);
		bus(1'b1, 5'h0c, 32'h200);
		bus(1'b1, 5'h10, 32'h300);
		rd(5'h08, 32'h40);
		slow <= 1'b1;
		inj({16'd2, 13'd1, 3'd3}, 1'b0);
		res(2'h2, 4'h1);
		ex(32'h14 + 4 * 2);
		ex(32'h100 + 32'h40 + (8 + 3) * 2);
		ex(32'h200 + 32'h40 + 29 / 8);
		slow <= 1'b0;
		inj({16'd2, 13'd1, 3'd4}, 1'b0);
		res(2'h1, 4'h0);
		seen.delete();
		inj({16'd2, 13'd1, 3'd4}, 1'b0);
		res(2'h0, 4'h0);
		chk(seen.size(), 0);
		rd(5'h14, 32'h0000_0100);
		inj(32'h0, 1'b1);
		res(2'h2, 4'hf);
		inj({16'd2, 13'd1, 3'd2}, 1'b0);
		res(2'h1, 4'h0);
		inj({16'd2, 13'd1, 3'd1}, 1'b0);
		res(2'h2, 4'hf);
		// clear cache, tagged format of width 2
		bus(1'b1, 5'h00, 32'h8000_0021);
		seen.delete();
		inj({16'd3, 13'd0, 3'd0}, 1'b0);
		res(2'h2, 4'h6);
		ex(32'h1c + 4 * 3);
		ex(32'h100);
		ex(32'h200 + 32'h80 + 5 * 2 / 8);
		ex(32'h300 + (2 - 1) * 2);
		inj({16'd3, 13'd0, 3'd1}, 1'b0);
		res(2'h1, 4'h0);
		chk(offchip_location, {16'h0003, 13'h0000, 3'h1});
		rd(5'h14, 32'h0000_0100);
		test_done();
	end
endmodule
